// [logic/ceu_pkg.sv]
// Constants, types and register map of the exception entry unit.
`default_nettype none
package ceu_pkg;
  localparam logic [4:0] MODE_USR = 5'h10;
  localparam logic [4:0] MODE_FIQ = 5'h11;
  localparam logic [4:0] MODE_IRQ = 5'h12;
  localparam logic [4:0] MODE_SVC = 5'h13;
  localparam logic [4:0] MODE_ABT = 5'h17;
  localparam logic [4:0] MODE_UND = 5'h1B;
  localparam logic [4:0] MODE_SYS = 5'h1F;
  localparam logic [31:0] VEC_RESET = 32'h0000_0000;
  localparam logic [31:0] VEC_UNDEF = 32'h0000_0004;
  localparam logic [31:0] VEC_TRAP  = 32'h0000_0008;
  localparam logic [31:0] VEC_PABT  = 32'h0000_000C;
  localparam logic [31:0] VEC_DABT  = 32'h0000_0010;
  localparam logic [31:0] VEC_IRQ   = 32'h0000_0018;
  localparam logic [31:0] VEC_FIQ   = 32'h0000_001C;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;
  localparam logic [31:0] OFS_NEXT  = 32'h0000_0004;
  localparam logic [31:0] OFS_DABT  = 32'h0000_0008;
  localparam logic [7:0]  REG_STATUS = 8'h00;
  localparam logic [7:0]  REG_SAVED  = 8'h04;
  localparam logic [7:0]  REG_LINK   = 8'h08;
  localparam logic [7:0]  REG_PEND   = 8'h0C;
  localparam logic [7:0]  REG_LASTV  = 8'h10;
  localparam int SYNC_MAX_CYC = 3;
  localparam int FAST_BANK_REGS = 7;
  typedef struct packed {
    logic [3:0]  flags;
    logic [19:0] rsvd;
    logic        irq_mask;
    logic        fiq_mask;
    logic        compact;
    logic [4:0]  mode;
  } ceu_status_t;
  typedef enum logic [1:0] {
    XF_NONE   = 2'b00,
    XF_SINGLE = 2'b01,
    XF_SWAP   = 2'b10,
    XF_MULTI  = 2'b11
  } ceu_xkind_t;
  typedef struct packed {
    ceu_xkind_t kind;
    logic       wback;
  } ceu_xfer_t;
  typedef enum logic [1:0] {
    RET_ZERO = 2'b00,
    RET_FOUR = 2'b01,
    RET_EIGHT = 2'b10
  } ceu_ret_t;
  typedef enum logic [2:0] {
    EX_NONE  = 3'b000,
    EX_RESET = 3'b001,
    EX_DABT  = 3'b010,
    EX_FIQ   = 3'b011,
    EX_IRQ   = 3'b100,
    EX_PABT  = 3'b101,
    EX_UNDEF = 3'b110,
    EX_TRAP  = 3'b111
  } ceu_exc_t;
endpackage
`default_nettype wire

// [logic/ceu_exception_unit.sv]
// Exception entry, priority, return and reset sequencing with an APB view.
//
// Decided for this implementation: the placing of the registers and register access over APB.
`default_nettype none
module ceu_exception_unit (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              core_reset_n,
  input  wire logic              fast_irq_req_n,
  input  wire logic              normal_irq_req_n,
  input  wire logic              irq_sync_select,
  input  wire logic              mem_abort,
  input  wire logic              mem_cycle,
  input  wire logic              abort_on_fetch,
  input  wire logic              instr_done,
  input  wire logic [31:0]       instr_pc,
  input  wire logic              head_undef,
  input  wire logic              head_trap,
  input  wire logic              branch_flush,
  input  wire ceu_pkg::ceu_xfer_t xfer,
  input  wire logic              ret_req,
  input  wire ceu_pkg::ceu_ret_t ret_sub,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   vec_take,
  output logic [31:0]            vec_addr,
  output logic                   pc_load,
  output logic [31:0]            pc_load_addr,
  output ceu_pkg::ceu_status_t   status,
  output logic                   fast_bank_sel,
  output logic                   reset_fetch,
  output logic [31:0]            reset_fetch_addr,
  output logic                   wb_allow,
  output logic                   reg_load_block,
  output logic                   swap_cancel
);
  import ceu_pkg::*;

  function automatic logic [2:0] mode_slot(input logic [4:0] m);
    case (m)
      MODE_FIQ: mode_slot = 3'h0;
      MODE_IRQ: mode_slot = 3'h1;
      MODE_SVC: mode_slot = 3'h2;
      MODE_ABT: mode_slot = 3'h3;
      MODE_UND: mode_slot = 3'h4;
      default:  mode_slot = 3'h7;
    endcase
  endfunction

  function automatic logic mode_legal(input logic [4:0] m);
    mode_legal = (m == MODE_USR) || (m == MODE_SYS) || (mode_slot(m) != 3'h7);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.
  logic fq_m_r, fq_s_r, nq_m_r, nq_s_r, sel_m_r, sel_s_r;
  logic cr_m_r, cr_s_r, cr_d_r;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      fq_m_r  <= 1'b1;
      fq_s_r  <= 1'b1;
      nq_m_r  <= 1'b1;
      nq_s_r  <= 1'b1;
      sel_m_r <= 1'b0;
      sel_s_r <= 1'b0;
      cr_m_r  <= 1'b0;
      cr_s_r  <= 1'b0;
      cr_d_r  <= 1'b0;
    end
    else
    begin
      fq_m_r  <= fast_irq_req_n;
      fq_s_r  <= fq_m_r;
      nq_m_r  <= normal_irq_req_n;
      nq_s_r  <= nq_m_r;
      sel_m_r <= irq_sync_select;
      sel_s_r <= sel_m_r;
      cr_m_r  <= core_reset_n;
      cr_s_r  <= cr_m_r;
      cr_d_r  <= cr_s_r;
    end
  end

  wire fast_lvl_n = sel_s_r ? fast_irq_req_n : fq_s_r;
  wire norm_lvl_n = sel_s_r ? normal_irq_req_n : nq_s_r;
  wire in_reset   = ~cr_s_r;
  wire reset_rel  = cr_s_r & ~cr_d_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Abort tracking and exception selection.
  ceu_status_t st_r;
  logic        pf_tag_r, da_pend_r, blk_r, chain_r, swap_cancel_r;
  wire da_evt   = mem_abort & mem_cycle & ~abort_on_fetch;
  wire pf_evt   = mem_abort & mem_cycle & abort_on_fetch;
  wire da_any   = da_evt | da_pend_r;
  wire fiq_live = ~fast_lvl_n & ~st_r.fiq_mask;
  wire irq_live = ~norm_lvl_n & ~st_r.irq_mask;
  wire boundary = instr_done & ~in_reset;
  wire pf_head  = pf_tag_r & ~branch_flush;

  ceu_exc_t exc;
  assign exc = reset_rel                   ? EX_RESET :
               (boundary & da_any)         ? EX_DABT  :
               ((boundary | chain_r) & fiq_live) ? EX_FIQ :
               (boundary & irq_live)       ? EX_IRQ   :
               (boundary & pf_head)        ? EX_PABT  :
               (boundary & head_undef)     ? EX_UNDEF :
               (boundary & head_trap)      ? EX_TRAP  : EX_NONE;

  logic [4:0]  ex_mode;
  logic [31:0] ex_vec;
  logic [31:0] ex_link;
  always_comb
  begin
    ex_mode = MODE_SVC;
    ex_vec  = VEC_RESET;
    ex_link = instr_pc + OFS_NEXT;
    case (exc)
      EX_RESET:
      begin
        ex_mode = MODE_SVC;
        ex_vec  = VEC_RESET;
        ex_link = instr_pc;
      end
      EX_DABT:
      begin
        ex_mode = MODE_ABT;
        ex_vec  = VEC_DABT;
        ex_link = instr_pc + OFS_DABT;
      end
      EX_FIQ:
      begin
        ex_mode = MODE_FIQ;
        ex_vec  = VEC_FIQ;
      end
      EX_IRQ:
      begin
        ex_mode = MODE_IRQ;
        ex_vec  = VEC_IRQ;
      end
      EX_PABT:
      begin
        ex_mode = MODE_ABT;
        ex_vec  = VEC_PABT;
      end
      EX_UNDEF:
      begin
        ex_mode = MODE_UND;
        ex_vec  = VEC_UNDEF;
      end
      EX_TRAP:
      begin
        ex_mode = MODE_SVC;
        ex_vec  = VEC_TRAP;
      end
      default:
      begin
        ex_mode = MODE_SVC;
        ex_vec  = VEC_RESET;
      end
    endcase
  end
  wire take = (exc != EX_NONE);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pf_tag_r      <= 1'b0;
      da_pend_r     <= 1'b0;
      blk_r         <= 1'b0;
      chain_r       <= 1'b0;
      swap_cancel_r <= 1'b0;
    end
    else
    begin
      pf_tag_r      <= in_reset ? 1'b0 : pf_evt | (pf_tag_r & ~branch_flush & ~instr_done);
      da_pend_r     <= in_reset ? 1'b0 : da_evt | (da_pend_r & ~instr_done);
      blk_r         <= ~instr_done & (blk_r | (da_evt & (xfer.kind == XF_MULTI)));
      chain_r       <= (exc == EX_DABT);
      swap_cancel_r <= da_evt & (xfer.kind == XF_SWAP);
    end
  end

  assign wb_allow       = xfer.wback & ~(da_any & (xfer.kind == XF_SWAP));
  assign reg_load_block = blk_r | (da_evt & (xfer.kind == XF_MULTI))
                          | (da_any & (xfer.kind == XF_SWAP));
  assign swap_cancel    = swap_cancel_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Status, banked link and saved status.
  logic [31:0] link_r  [0:4];
  logic [31:0] saved_r [0:4];
  wire [2:0] cur_slot = mode_slot(st_r.mode);
  wire [2:0] ent_slot = mode_slot(ex_mode);
  wire       cur_bank = (cur_slot != 3'h7);
  wire       ret_ok   = ret_req & cur_bank & ~take;
  wire [31:0] ret_ofs = (ret_sub == RET_EIGHT) ? OFS_DABT :
                        (ret_sub == RET_FOUR)  ? OFS_NEXT : 32'h0000_0000;

  wire        wr_acc  = psel & penable & pwrite;
  wire        wr_st   = wr_acc & (paddr == REG_STATUS);
  wire        wr_sv   = wr_acc & (paddr == REG_SAVED) & cur_bank;
  wire        wr_lk   = wr_acc & (paddr == REG_LINK) & cur_bank;
  wire        priv    = (st_r.mode != MODE_USR);
  ceu_status_t wst;
  assign wst.flags    = pwdata[31:28];
  assign wst.rsvd     = st_r.rsvd;
  assign wst.irq_mask = priv ? pwdata[7] : st_r.irq_mask;
  assign wst.fiq_mask = priv ? pwdata[6] : st_r.fiq_mask;
  assign wst.compact  = st_r.compact;
  assign wst.mode     = (priv & mode_legal(pwdata[4:0])) ? pwdata[4:0] : st_r.mode;

  ceu_status_t st_nxt;
  always_comb
  begin
    st_nxt = st_r;
    if (take)
    begin
      st_nxt.mode     = ex_mode;
      st_nxt.irq_mask = 1'b1;
      st_nxt.compact  = 1'b0;
      if ((exc == EX_FIQ) || (exc == EX_RESET))
        st_nxt.fiq_mask = 1'b1;
    end
    else if (ret_ok)
      st_nxt = saved_r[cur_slot];
    else if (wr_st & ~in_reset)
      st_nxt = wst;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_r <= '{flags: 4'h0, rsvd: 20'h00000, irq_mask: 1'b1, fiq_mask: 1'b1,
                compact: 1'b0, mode: MODE_SVC};
      for (int i = 0; i < 5; i++)
      begin
        link_r[i]  <= 32'h0000_0000;
        saved_r[i] <= 32'h0000_0000;
      end
    end
    else
    begin
      st_r <= st_nxt;
      if (take)
      begin
        link_r[ent_slot]  <= ex_link;
        saved_r[ent_slot] <= st_r;
      end
      else if (wr_sv)
        saved_r[cur_slot] <= pwdata;
      else if (wr_lk)
        link_r[cur_slot] <= pwdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Program flow outputs.
  logic        vec_take_r, pc_load_r, rf_r;
  logic [31:0] vec_addr_r, pc_load_addr_r, rf_addr_r;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      vec_take_r     <= 1'b0;
      vec_addr_r     <= VEC_RESET;
      pc_load_r      <= 1'b0;
      pc_load_addr_r <= 32'h0000_0000;
      rf_r           <= 1'b0;
      rf_addr_r      <= 32'h0000_0000;
    end
    else
    begin
      vec_take_r     <= take;
      vec_addr_r     <= take ? ex_vec : vec_addr_r;
      pc_load_r      <= ret_ok;
      pc_load_addr_r <= ret_ok ? link_r[cur_slot] - ret_ofs : pc_load_addr_r;
      rf_r           <= in_reset;
      rf_addr_r      <= in_reset ? rf_addr_r + WORD_STEP : VEC_RESET;
    end
  end

  assign vec_take         = vec_take_r;
  assign vec_addr         = vec_addr_r;
  assign pc_load          = pc_load_r;
  assign pc_load_addr     = pc_load_addr_r;
  assign status           = st_r;
  assign fast_bank_sel    = (st_r.mode == MODE_FIQ);
  assign reset_fetch      = rf_r;
  assign reset_fetch_addr = rf_addr_r;

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states.
  wire hit = (paddr == REG_STATUS) || (paddr == REG_SAVED) || (paddr == REG_LINK) ||
             (paddr == REG_PEND) || (paddr == REG_LASTV);
  wire [31:0] pend_word = {27'h0000000, pf_tag_r, da_pend_r, blk_r, ~norm_lvl_n, ~fast_lvl_n};
  wire [31:0] rd_mux = (paddr == REG_STATUS) ? st_r :
                       (paddr == REG_SAVED)  ? (cur_bank ? saved_r[cur_slot] : 32'h0000_0000) :
                       (paddr == REG_LINK)   ? (cur_bank ? link_r[cur_slot] : 32'h0000_0000) :
                       (paddr == REG_PEND)   ? pend_word :
                       (paddr == REG_LASTV)  ? vec_addr_r : 32'h0000_0000;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata  = (psel & penable & ~pwrite) ? rd_mux : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  a_fiq_entry_mask: assert property (@(posedge clk) disable iff (rst)
    (exc == EX_FIQ) |=> (st_r.mode == MODE_FIQ) && st_r.fiq_mask && st_r.irq_mask)
    else $error("fast entry did not set mode and both masks");
  a_fiq_vector: assert property (@(posedge clk) disable iff (rst)
    (exc == EX_FIQ) |=> vec_take && (vec_addr == VEC_FIQ))
    else $error("fast entry vector wrong");
  a_dabt_over_fiq: assert property (@(posedge clk) disable iff (rst)
    (boundary && da_any && !reset_rel) |-> (exc == EX_DABT))
    else $error("data abort lost priority");
  a_dabt_chain_fiq: assert property (@(posedge clk) disable iff (rst)
    (exc == EX_DABT) ##1 (fiq_live && !reset_rel) |-> (exc == EX_FIQ))
    else $error("fast entry did not follow data abort");
  a_user_masks: assert property (@(posedge clk) disable iff (rst)
    (wr_st && !take && !ret_ok && !in_reset && st_r.mode == MODE_USR)
      |=> $stable(st_r.fiq_mask) && $stable(st_r.irq_mask))
    else $error("user mode changed a mask");
  a_reset_release: assert property (@(posedge clk) disable iff (rst)
    reset_rel |=> (st_r.mode == MODE_SVC) && st_r.irq_mask && st_r.fiq_mask
      && !st_r.compact && (vec_addr == VEC_RESET) && vec_take)
    else $error("reset release state wrong");
  a_reset_fetch: assert property (@(posedge clk) disable iff (rst)
    (in_reset ##1 in_reset) |=> (reset_fetch_addr == $past(reset_fetch_addr) + WORD_STEP))
    else $error("reset fetch did not step by a word");
  a_return_pc: assert property (@(posedge clk) disable iff (rst)
    (ret_ok && ret_sub == RET_EIGHT) |=> pc_load && (pc_load_addr == $past(link_r[cur_slot]) - OFS_DABT))
    else $error("return address wrong");
  a_sync_latency: assert property (@(posedge clk) disable iff (rst)
    (!sel_s_r && !fast_irq_req_n) ##1 (!sel_s_r && !fast_irq_req_n) |=> !fast_lvl_n)
    else $error("synchroniser slower than allowed");
  a_swap_undo: assert property (@(posedge clk) disable iff (rst)
    (da_evt && xfer.kind == XF_SWAP) |-> !wb_allow && reg_load_block ##1 swap_cancel)
    else $error("aborted swap changed state");
  a_trap_entry: assert property (@(posedge clk) disable iff (rst)
    (exc == EX_TRAP) |=> (st_r.mode == MODE_SVC) && (vec_addr == VEC_TRAP))
    else $error("software trap entry wrong");
  a_undef_entry: assert property (@(posedge clk) disable iff (rst)
    (exc == EX_UNDEF) |=> (st_r.mode == MODE_UND) && (vec_addr == VEC_UNDEF))
    else $error("undefined trap entry wrong");
  a_fetch_link: assert property (@(posedge clk) disable iff (rst)
    (exc == EX_PABT) |=> (link_r[mode_slot(MODE_ABT)] == $past(instr_pc) + OFS_NEXT))
    else $error("fetch abort link wrong");
  a_data_link: assert property (@(posedge clk) disable iff (rst)
    (exc == EX_DABT) |=> (link_r[mode_slot(MODE_ABT)] == $past(instr_pc) + OFS_DABT))
    else $error("data abort link wrong");
  a_fetch_flush: assert property (@(posedge clk) disable iff (rst)
    (pf_tag_r && branch_flush && !pf_evt) |=> !pf_tag_r)
    else $error("flushed fetch abort kept");
  a_multi_block: assert property (@(posedge clk) disable iff (rst)
    (da_evt && xfer.kind == XF_MULTI) |-> reg_load_block && (wb_allow == xfer.wback))
    else $error("aborted multi transfer not handled");
  a_single_wback: assert property (@(posedge clk) disable iff (rst)
    (da_any && xfer.kind == XF_SINGLE) |-> (wb_allow == xfer.wback))
    else $error("aborted single transfer lost write-back");
  a_irq_priority: assert property (@(posedge clk) disable iff (rst)
    (boundary && irq_live && !da_any && !fiq_live && !reset_rel) |-> (exc == EX_IRQ))
    else $error("normal interrupt not taken");
  a_reset_hold: assert property (@(posedge clk) disable iff (rst)
    in_reset |=> reset_fetch)
    else $error("held reset did not fetch");
endmodule // ceu_exception_unit
`default_nettype wire

// [test/ceu_far_side.sv]
// Behavioural interrupt controller and memory system facing the exception unit.
`default_nettype none
module ceu_far_side (
  input  wire logic clk,
  input  wire logic fiq_on,
  input  wire logic irq_on,
  input  wire logic abt_go,
  input  wire logic abt_fetch,
  output logic      fast_irq_req_n,
  output logic      normal_irq_req_n,
  output logic      mem_abort,
  output logic      mem_cycle,
  output logic      abort_on_fetch
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    fast_irq_req_n = 1'b1;
    normal_irq_req_n = 1'b1;
    mem_abort = 1'b0;
    mem_cycle = 1'b0;
    abort_on_fetch = 1'b0;
  end
  // Requests are plain levels; an abort comes only inside a memory cycle.
  always @(posedge clk)
  begin
    fast_irq_req_n <= ~fiq_on;
    normal_irq_req_n <= ~irq_on;
    mem_cycle <= abt_go | ~mem_cycle;
    mem_abort <= abt_go;
    abort_on_fetch <= abt_go ? abt_fetch : ~abort_on_fetch;
  end
endmodule // ceu_far_side
`default_nettype wire

// [test/ceu_exception_unit_bench.sv]
// Self-checking bench for the exception entry unit.
`default_nettype none
module ceu_exception_unit_bench import ceu_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, core_reset_n, irq_sync_select, instr_done, head_undef, head_trap, err;
  logic branch_flush, ret_req, psel, penable, pwrite, fiq_on, irq_on, abt_go, abt_fetch;
  logic [31:0] instr_pc, pwdata, prdata, vec_addr, pc_load_addr, reset_fetch_addr, rd, pc;
  logic [7:0] paddr;
  ceu_xfer_t xfer;
  ceu_ret_t ret_sub;
  ceu_status_t status;
  logic fast_irq_req_n, normal_irq_req_n, mem_abort, mem_cycle, abort_on_fetch, pready;
  logic pslverr, vec_take, pc_load, fast_bank_sel, reset_fetch, wb_allow, reg_load_block;
  logic swap_cancel;
  int mismatches, check_count, c;
  ceu_exc_t kinds [8] = '{EX_DABT, EX_DABT, EX_DABT, EX_FIQ, EX_IRQ, EX_PABT, EX_UNDEF, EX_TRAP};
  ceu_exception_unit dut (.clk(clk), .rst(rst), .core_reset_n(core_reset_n),
    .fast_irq_req_n(fast_irq_req_n), .normal_irq_req_n(normal_irq_req_n),
    .irq_sync_select(irq_sync_select), .mem_abort(mem_abort), .mem_cycle(mem_cycle),
    .abort_on_fetch(abort_on_fetch), .instr_done(instr_done), .instr_pc(instr_pc),
    .head_undef(head_undef), .head_trap(head_trap), .branch_flush(branch_flush),
    .xfer(xfer), .ret_req(ret_req), .ret_sub(ret_sub), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .vec_take(vec_take), .vec_addr(vec_addr), .pc_load(pc_load),
    .pc_load_addr(pc_load_addr), .status(status), .fast_bank_sel(fast_bank_sel),
    .reset_fetch(reset_fetch), .reset_fetch_addr(reset_fetch_addr), .wb_allow(wb_allow),
    .reg_load_block(reg_load_block), .swap_cancel(swap_cancel));
  ceu_far_side far (.clk(clk), .fiq_on(fiq_on), .irq_on(irq_on), .abt_go(abt_go),
    .abt_fetch(abt_fetch), .fast_irq_req_n(fast_irq_req_n),
    .normal_irq_req_n(normal_irq_req_n), .mem_abort(mem_abort), .mem_cycle(mem_cycle),
    .abort_on_fetch(abort_on_fetch));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic await(ref logic sig, input int lim, output int cyc);
    for (cyc = 0; cyc < lim && sig !== 1'b1; cyc++)
      @(posedge clk);
  endtask
  task automatic fire(input logic und, input logic trp);
    instr_done <= 1'b1;
    instr_pc <= pc;
    head_undef <= und;
    head_trap <= trp;
    @(posedge clk);
    instr_done <= 1'b0;
    head_undef <= 1'b0;
    head_trap <= 1'b0;
  endtask
  task automatic do_ret(input ceu_ret_t s);
    ret_req <= 1'b1;
    ret_sub <= s;
    @(posedge clk);
    ret_req <= 1'b0;
    await(pc_load, 4, c);
    @(posedge clk);
  endtask
  task automatic raise(input logic f, input logic i, input logic a, input logic af);
    fiq_on <= f;
    irq_on <= i;
    abt_go <= a;
    abt_fetch <= af;
    @(posedge clk);
    abt_go <= 1'b0;
  endtask
  function automatic logic [31:0] exp_vec(input ceu_exc_t k);
    case (k)
      EX_DABT: exp_vec = VEC_DABT;
      EX_FIQ: exp_vec = VEC_FIQ;
      EX_IRQ: exp_vec = VEC_IRQ;
      EX_PABT: exp_vec = VEC_PABT;
      EX_UNDEF: exp_vec = VEC_UNDEF;
      default: exp_vec = VEC_TRAP;
    endcase
  endfunction
  function automatic logic [4:0] exp_mode(input ceu_exc_t k);
    case (k)
      EX_DABT, EX_PABT: exp_mode = MODE_ABT;
      EX_FIQ: exp_mode = MODE_FIQ;
      EX_IRQ: exp_mode = MODE_IRQ;
      EX_UNDEF: exp_mode = MODE_UND;
      default: exp_mode = MODE_SVC;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  task automatic run_exc(input ceu_exc_t k, input ceu_xkind_t xk);
    logic [31:0] lnk;
    ceu_ret_t rs;
    pc = $urandom() & 32'hFFFF_FFFC;
    lnk = pc + ((k == EX_DABT) ? OFS_DABT : OFS_NEXT);
    rs = (k == EX_DABT) ? RET_EIGHT : RET_FOUR;
    if (k == EX_UNDEF || k == EX_TRAP)
      rs = RET_ZERO;
    apb(1'b1, REG_STATUS, 32'h0000_0013);
    xfer <= '{kind: xk, wback: 1'b1};
    raise(k == EX_FIQ, k == EX_IRQ, k == EX_DABT || k == EX_PABT, k == EX_PABT);
    await(swap_cancel, 4, c);
    repeat (2) @(posedge clk);
    if (k == EX_DABT)
    begin
      check("swap cancel", c < 4, xk == XF_SWAP);
      check("write back", wb_allow, xk != XF_SWAP);
      check("load block", reg_load_block, xk != XF_SINGLE);
    end
    fire(k == EX_UNDEF, k == EX_TRAP);
    await(vec_take, 4, c);
    check("entry latency", c <= 2, 1'b1);
    fiq_on <= 1'b0;
    irq_on <= 1'b0;
    @(posedge clk);
    check("vector", vec_addr, exp_vec(k));
    check("mode", status.mode, exp_mode(k));
    check("normal mask", status.irq_mask, 1'b1);
    check("fast mask", status.fiq_mask, k == EX_FIQ);
    check("fast bank", fast_bank_sel, k == EX_FIQ);
    apb(1'b0, REG_LINK, 32'h0);
    check("link", rd, lnk);
    apb(1'b0, REG_SAVED, 32'h0);
    check("saved", rd, 32'h0000_0013);
    do_ret(rs);
    check("return pc", pc_load_addr, (rs == RET_ZERO) ? lnk : pc);
    check("restored", status, 32'h0000_0013);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #(25 * 6000);
    mismatches++;
    final_report();
  end
  initial
  begin
    {rst, core_reset_n, irq_sync_select, instr_done, head_undef, head_trap} = 6'h20;
    {branch_flush, ret_req, psel, penable, pwrite, fiq_on, irq_on, abt_go, abt_fetch} = 9'h0;
    {instr_pc, pwdata, paddr, pc} = '0;
    xfer = '{kind: XF_NONE, wback: 1'b0};
    ret_sub = RET_ZERO;
    mismatches = 0;
    check_count = 0;
    void'($urandom(72));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    rd = reset_fetch_addr;
    @(posedge clk);
    check("reset fetch", reset_fetch, 1'b1);
    check("reset step", reset_fetch_addr, rd + WORD_STEP);
    core_reset_n <= 1'b1;
    await(vec_take, 8, c);
    @(posedge clk);
    check("reset vector", vec_addr, VEC_RESET);
    check("reset status", status, 32'h0000_00D3);
    $display("test reset done");
    for (int i = 0; i < 16; i++)
      run_exc(kinds[i % 8], ceu_xkind_t'(i % 3 + 1));
    $display("test entries done");
    apb(1'b1, REG_STATUS, 32'h0000_0013);
    raise(1'b1, 1'b1, 1'b1, 1'b0);
    repeat (5) @(posedge clk);
    fire(1'b1, 1'b0);
    await(vec_take, 4, c);
    check("first vector", vec_addr, VEC_DABT);
    @(posedge clk);
    await(vec_take, 4, c);
    check("second vector", vec_addr, VEC_FIQ);
    raise(1'b0, 1'b0, 1'b0, 1'b0);
    do_ret(RET_FOUR);
    check("resume abort", status.mode, MODE_ABT);
    do_ret(RET_EIGHT);
    $display("test priority done");
    apb(1'b1, REG_STATUS, 32'h0000_0053);
    raise(1'b1, 1'b1, 1'b0, 1'b0);
    repeat (5) @(posedge clk);
    fire(1'b0, 1'b0);
    await(vec_take, 4, c);
    check("masked fast", vec_addr, VEC_IRQ);
    raise(1'b0, 1'b0, 1'b0, 1'b0);
    do_ret(RET_FOUR);
    apb(1'b1, REG_STATUS, 32'h0000_00D3);
    raise(1'b1, 1'b1, 1'b0, 1'b0);
    repeat (5) @(posedge clk);
    fire(1'b0, 1'b0);
    await(vec_take, 6, c);
    check("both masked", c, 6);
    raise(1'b0, 1'b0, 1'b0, 1'b0);
    apb(1'b1, REG_STATUS, 32'h0000_0010);
    apb(1'b1, REG_STATUS, 32'hF000_00D3);
    apb(1'b0, REG_STATUS, 32'h0);
    check("user write", rd, 32'hF000_0010);
    fire(1'b0, 1'b1);
    await(vec_take, 4, c);
    @(posedge clk);
    check("trap mode", status.mode, MODE_SVC);
    irq_sync_select <= 1'b1;
    repeat (3) @(posedge clk);
    raise(1'b1, 1'b0, 1'b0, 1'b0);
    fire(1'b0, 1'b0);
    await(vec_take, 4, c);
    check("direct fast", vec_addr, VEC_FIQ);
    raise(1'b0, 1'b0, 1'b0, 1'b0);
    irq_sync_select <= 1'b0;
    do_ret(RET_FOUR);
    $display("test masks done");
    raise(1'b0, 1'b0, 1'b1, 1'b1);
    repeat (3) @(posedge clk);
    branch_flush <= 1'b1;
    @(posedge clk);
    branch_flush <= 1'b0;
    @(posedge clk);
    fire(1'b0, 1'b0);
    await(vec_take, 6, c);
    check("flushed abort", c, 6);
    apb(1'b0, 8'h20, 32'h0);
    check("unmapped error", err, 1'b1);
    check("unmapped data", rd, 32'h0);
    $display("test flush and bus done");
    final_report();
  end
endmodule // ceu_exception_unit_bench
`default_nettype wire
